/* fcm_defines.vh */
/*
 * constants of the flash command-mode host controller: register map,
 * command codes, bus sequences, pin timing.
 * assumes a 100 MHz aclk and a parallel NOR flash on the far side.
 */
`ifndef FCM_DEFINES_VH
`define FCM_DEFINES_VH
// register byte offsets
`define FCM_REG_CTRL 8'h00
`define FCM_REG_ADDR 8'h04
`define FCM_REG_WDATA 8'h08
`define FCM_REG_RDATA 8'h0c
`define FCM_REG_STAT 8'h10
`define FCM_REG_CFG 8'h14
// status fields
`define FCM_ST_BUSY 0
`define FCM_ST_ESUSP 3
`define FCM_ST_FAIL 4
`define FCM_ST_ABORT 5
`define FCM_ST_ERR 6
// axi responses
`define FCM_RESP_OKAY 2'h0
`define FCM_RESP_SLVERR 2'h2
`define FCM_RESP_DECERR 2'h3
// host commands, ctrl[3:0]
`define FCM_CMD_READ 4'h0
`define FCM_CMD_RESET 4'h1
`define FCM_CMD_AUTOSEL 4'h2
`define FCM_CMD_QUERY 4'h3
`define FCM_CMD_SEC_ENTER 4'h4
`define FCM_CMD_SEC_EXIT 4'h5
`define FCM_CMD_BUF_ABORT 4'h6
`define FCM_CMD_RAW 4'h7
`define FCM_CMD_POLL 4'h8
// tracked device modes
`define FCM_MODE_READ 2'h0
`define FCM_MODE_AUTOSEL 2'h1
`define FCM_MODE_QUERY 2'h2
`define FCM_MODE_SEC 2'h3
// bus cycle addresses and data
`define FCM_UNLOCK1_A 12'h555
`define FCM_UNLOCK2_A 12'h2aa
`define FCM_QUERY_A 12'h055
`define FCM_UNLOCK1_D 8'haa
`define FCM_UNLOCK2_D 8'h55
`define FCM_RESET_D 8'hf0
`define FCM_AUTOSEL_D 8'h90
`define FCM_QUERY_D 8'h98
`define FCM_SEC_ENTER_D 8'h88
`define FCM_SEC_EXIT2_D 8'h00
`define FCM_SUSPEND_D 8'hb0
`define FCM_RESUME_D 8'h30
`define FCM_BYPASS_D 8'h20
// fail and abort status bits of the data bus
`define FCM_DQ_FAIL 5
`define FCM_DQ_ABORT 1
// pin timing
`define FCM_CLK_NS 10
`define FCM_T_ACC_NS 90
`define FCM_T_WE_NS 35
`define FCM_SYNC_CYC 2
`define FCM_RD_CYC ((`FCM_T_ACC_NS + `FCM_CLK_NS - 1) / `FCM_CLK_NS + `FCM_SYNC_CYC)
`define FCM_WE_CYC ((`FCM_T_WE_NS + `FCM_CLK_NS - 1) / `FCM_CLK_NS)
`endif

/* fcm_flash_model.sv */
/* behavioural flash on the host pins: command decode and mode reads.
   assumes word addresses on addr, doubled when byte_m is high. */
`include "fcm_tb_fn.svh"
module fcm_flash_model (
   // strobes
   input wire ce_n,
   input wire we_n,
   input wire oe_n,
   // address and data
   input wire [22:0] addr,
   input wire [15:0] dq,
   output wire [15:0] dq_i,
   // bench controls
   input wire byte_m,
   input wire [1:0] inj
);
   logic [22:0] la;
   logic [19:0] h1, h2, e;
   logic [1:0] md = 2'h0;
   logic [15:0] rd, lst;
   wire wr_n = ce_n | we_n;
   wire rd_on = !ce_n && !oe_n;
   wire [22:0] wa = byte_m ? addr >> 1 : addr;
   always @(negedge wr_n) la = wa;
   always @(posedge wr_n) begin
      e = {la[11:0], dq[7:0]};
      if (dq[7:0] == 8'hf0 && md != 2'h3) md = 2'h0;
      else if (e == 20'h05598 && md == 2'h0) md = 2'h2;
      else if ({h1, h2, e} == 60'h555aa_2aa55_55590 && md != 2'h3) md = 2'h1;
      else if ({h1, h2, e} == 60'h555aa_2aa55_55588) md = 2'h3;
      else if ({h2, e} == 40'h55590_00000 && md == 2'h3) md = 2'h0;
      h1 = h2;
      h2 = e;
   end
   // fail on bit 5, abort on bit 1; released bus shows the inverse
   always @* begin
      rd = fcm_dval(wa, md) | {10'h0, inj[1], 3'h0, inj[0], 1'h0};
      if (rd_on) lst = rd;
   end
   assign dq_i = rd_on ? rd : ~lst;
endmodule // fcm_flash_model

/* fcm_host.v */
/*
 * host controller that issues command sequences and reads to a parallel
 * NOR flash through its chip-select, write and output strobes.
 * assumes software on an axi4-lite bus and the flash pins on the far side.
 */
// Behaviour
// RULE1: device latches address at the later falling edge of write or select.
// RULE2: device latches data at the earlier rising edge of write or select.
// RULE3: after power-up the device reads the array with no command.
// RULE4: device returns to array reads after embedded program or erase.
// RULE5: erase suspend gives reads of all sectors except the suspended one.
// RULE6: host writes only valid sequences, and reset after an improper one.
// RULE7: on fail status the host writes reset; device returns to read mode.
// RULE8: reset inside an erase sequence returns to read; ignored once erasing.
// RULE9: reset inside a program sequence returns to read or suspend-read.
// RULE10: only reset leaves autoselect, back to read or erase-suspend-read; mode_q also leaves it on secured sector enter or exit.
// RULE11: on buffer abort status the host writes the abort reset sequence.
// RULE12: autoselect is two unlock cycles then the autoselect command.
// RULE13: in autoselect the device answers reads repeatedly at any address.
// RULE14: autoselect gives maker code at 00h, device code at 01h, 0Eh, 0Fh.
// RULE15: autoselect gives secured lock at 03h, protection at sector plus 02h.
// RULE16: three-cycle enter opens the secured sector; four-cycle exit closes it.
// RULE17: no accelerated supply or unlock bypass while secured sector open.
// RULE18: query words 40h-44h give P, R, I and version 1.3.
// RULE19: query word 45h holds unlock need and process code.
// RULE20: query 46h gives 0002h, query 50h gives 0001h.
// RULE21: query 49h gives 0008h, query 48h gives 0000h.
// RULE22: query 4Fh gives the boot sector layout code.
// RULE23: in byte mode each location sits at twice its word address.
`include "fcm_defines.vh"
module fcm_host #(
   parameter AW = 23
) (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // axi4-lite slave
   input wire [7:0] s_awaddr,
   input wire s_awvalid,
   output reg s_awready,
   input wire [31:0] s_wdata,
   input wire [3:0] s_wstrb,
   input wire s_wvalid,
   output reg s_wready,
   output reg [1:0] s_bresp,
   output reg s_bvalid,
   input wire s_bready,
   input wire [7:0] s_araddr,
   input wire s_arvalid,
   output reg s_arready,
   output reg [31:0] s_rdata,
   output reg [1:0] s_rresp,
   output reg s_rvalid,
   input wire s_rready,
   // flash pins
   output reg flash_ce_n,
   output reg flash_we_n,
   output reg flash_oe_n,
   output reg [AW-1:0] flash_addr,
   output reg [15:0] flash_dq_o,
   output reg flash_dq_oe,
   input wire [15:0] flash_dq_i
);
   localparam S_IDLE = 3'h0;
   localparam S_WSET = 3'h1;
   localparam S_WLOW = 3'h2;
   localparam S_WHOLD = 3'h3;
   localparam S_RLOW = 3'h4;
   localparam integer RD_CYC_I = `FCM_RD_CYC;
   localparam integer WE_CYC_I = `FCM_WE_CYC;
   localparam [3:0] RD_CYC = RD_CYC_I[3:0];
   localparam [3:0] WE_CYC = WE_CYC_I[3:0];

   // sequence entry: {last, user_addr, addr[11:0], data[7:0]}
   function [21:0] fcm_seq;
      input [3:0] cmd;
      input [1:0] idx;
      begin
         fcm_seq = {2'b10, 12'h000, `FCM_RESET_D};
         case (cmd)
            `FCM_CMD_AUTOSEL, `FCM_CMD_SEC_ENTER, `FCM_CMD_BUF_ABORT, `FCM_CMD_SEC_EXIT: begin
               case (idx)
                  2'h0: fcm_seq = {2'b00, `FCM_UNLOCK1_A, `FCM_UNLOCK1_D};
                  2'h1: fcm_seq = {2'b00, `FCM_UNLOCK2_A, `FCM_UNLOCK2_D};
                  2'h2: begin
                     if (cmd == `FCM_CMD_AUTOSEL)
                        fcm_seq = {2'b10, `FCM_UNLOCK1_A, `FCM_AUTOSEL_D}; // RULE12
                     else if (cmd == `FCM_CMD_SEC_ENTER)
                        fcm_seq = {2'b10, `FCM_UNLOCK1_A, `FCM_SEC_ENTER_D}; // RULE16
                     else if (cmd == `FCM_CMD_BUF_ABORT)
                        fcm_seq = {2'b10, `FCM_UNLOCK1_A, `FCM_RESET_D}; // RULE11
                     else
                        fcm_seq = {2'b00, `FCM_UNLOCK1_A, `FCM_AUTOSEL_D};
                  end
                  default: fcm_seq = {2'b10, 12'h000, `FCM_SEC_EXIT2_D}; // RULE16
               endcase
            end
            `FCM_CMD_QUERY: fcm_seq = {2'b10, `FCM_QUERY_A, `FCM_QUERY_D};
            `FCM_CMD_RAW: fcm_seq = {2'b11, 12'h000, 8'h00};
            default: fcm_seq = {2'b10, 12'h000, `FCM_RESET_D}; // RULE6 RULE8 RULE9
         endcase
      end
   endfunction

   reg [2:0] st_q;
   reg [3:0] cnt_q;
   reg [1:0] idx_q;
   reg [3:0] cmd_q;
   reg [1:0] mode_q;
   reg esusp_q, fail_q, abort_q, err_q, byte_q;
   reg [AW-1:0] addr_q;
   reg [15:0] wdata_q, rdata_q;
   reg [15:0] dq_s1_q, dq_s2_q;
   reg [7:0] awaddr_q;
   reg [31:0] wbuf_q;
   reg aw_held_q, w_held_q;
   wire [21:0] seq_w = fcm_seq(cmd_q, idx_q);
   wire [AW-1:0] pin_addr_w = seq_w[20] ? addr_q : {{(AW-12){1'b0}}, seq_w[19:8]};
   wire [15:0] pin_data_w = seq_w[20] ? wdata_q : {8'h00, seq_w[7:0]};
   wire [3:0] new_cmd_w = wbuf_q[3:0];
   wire wr_go_w = aw_held_q && w_held_q && !s_bvalid;
   reg s_wstrb_ok_q;
   wire ctrl_wr_w = wr_go_w && awaddr_q == `FCM_REG_CTRL && s_wstrb_ok_q;
   // refuse while busy, while a pending failure or abort needs its reset
   wire refuse_w = st_q != S_IDLE ||
      (abort_q && new_cmd_w != `FCM_CMD_BUF_ABORT) || // RULE11
      (fail_q && new_cmd_w != `FCM_CMD_RESET && new_cmd_w != `FCM_CMD_POLL) || // RULE7
      (mode_q == `FCM_MODE_SEC && new_cmd_w == `FCM_CMD_RAW && wdata_q[7:0] == `FCM_BYPASS_D) || // RULE17
      new_cmd_w > `FCM_CMD_POLL;
   wire start_w = ctrl_wr_w && !refuse_w;
   wire [15:0] stat_w = {9'h000, err_q, abort_q, fail_q, esusp_q, mode_q, st_q != S_IDLE};

   // dq input synchroniser
   always @(posedge aclk) begin
      dq_s1_q <= flash_dq_i;
      dq_s2_q <= dq_s1_q;
   end

   // axi write channel
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         s_awready <= 1'b1;
         s_wready <= 1'b1;
         s_bvalid <= 1'b0;
         s_bresp <= `FCM_RESP_OKAY;
         awaddr_q <= 8'h00;
         wbuf_q <= 32'h0;
         s_wstrb_ok_q <= 1'b0;
      end else begin
         if (s_awvalid && s_awready) begin
            awaddr_q <= s_awaddr;
            aw_held_q <= 1'b1;
            s_awready <= 1'b0;
         end
         if (s_wvalid && s_wready) begin
            wbuf_q <= s_wdata;
            s_wstrb_ok_q <= s_wstrb[0];
            w_held_q <= 1'b1;
            s_wready <= 1'b0;
         end
         if (wr_go_w) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            s_bvalid <= 1'b1;
            if (awaddr_q > `FCM_REG_CFG || awaddr_q[1:0] != 2'h0)
               s_bresp <= `FCM_RESP_DECERR;
            else if (ctrl_wr_w && refuse_w)
               s_bresp <= `FCM_RESP_SLVERR;
            else
               s_bresp <= `FCM_RESP_OKAY;
         end
         if (s_bvalid && s_bready) begin
            s_bvalid <= 1'b0;
            s_awready <= 1'b1;
            s_wready <= 1'b1;
         end
      end
   end

   // axi read channel
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_arready <= 1'b1;
         s_rvalid <= 1'b0;
         s_rdata <= 32'h0;
         s_rresp <= `FCM_RESP_OKAY;
      end else if (s_arvalid && s_arready) begin
         s_arready <= 1'b0;
         s_rvalid <= 1'b1;
         s_rresp <= `FCM_RESP_OKAY;
         case (s_araddr)
            `FCM_REG_CTRL: s_rdata <= {28'h0, cmd_q};
            `FCM_REG_ADDR: s_rdata <= {{(32-AW){1'b0}}, addr_q};
            `FCM_REG_WDATA: s_rdata <= {16'h0, wdata_q};
            `FCM_REG_RDATA: s_rdata <= {16'h0, rdata_q};
            `FCM_REG_STAT: s_rdata <= {16'h0, stat_w};
            `FCM_REG_CFG: s_rdata <= {31'h0, byte_q};
            default: begin
               s_rdata <= 32'h0;
               s_rresp <= `FCM_RESP_DECERR;
            end
         endcase
      end else if (s_rvalid && s_rready) begin
         s_rvalid <= 1'b0;
         s_arready <= 1'b1;
      end
   end

   // registers, pin sequencer and mode tracking
   always @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= S_IDLE;
         cnt_q <= 4'h0;
         idx_q <= 2'h0;
         cmd_q <= `FCM_CMD_READ;
         mode_q <= `FCM_MODE_READ; // RULE3
         esusp_q <= 1'b0;
         fail_q <= 1'b0;
         abort_q <= 1'b0;
         err_q <= 1'b0;
         byte_q <= 1'b0;
         addr_q <= {AW{1'b0}};
         wdata_q <= 16'h0;
         rdata_q <= 16'h0;
         flash_ce_n <= 1'b1;
         flash_we_n <= 1'b1;
         flash_oe_n <= 1'b1;
         flash_addr <= {AW{1'b0}};
         flash_dq_o <= 16'h0;
         flash_dq_oe <= 1'b0;
      end else begin
         if (wr_go_w && s_wstrb_ok_q) begin
            if (awaddr_q == `FCM_REG_ADDR)
               addr_q <= wbuf_q[AW-1:0];
            if (awaddr_q == `FCM_REG_WDATA)
               wdata_q <= wbuf_q[15:0];
            if (awaddr_q == `FCM_REG_CFG)
               byte_q <= wbuf_q[0];
            if (awaddr_q == `FCM_REG_STAT && wbuf_q[`FCM_ST_ERR])
               err_q <= 1'b0;
         end
         if (ctrl_wr_w && refuse_w)
            err_q <= 1'b1;
         case (st_q)
            S_IDLE: begin
               if (start_w) begin
                  cmd_q <= new_cmd_w;
                  idx_q <= 2'h0;
                  st_q <= (new_cmd_w == `FCM_CMD_READ || new_cmd_w == `FCM_CMD_POLL) ? S_RLOW : S_WSET;
                  cnt_q <= 4'h0;
               end
            end
            S_WSET: begin
               // address set in the same cycle as select falls, one cycle before write falls
               flash_addr <= byte_q ? {pin_addr_w[AW-2:0], 1'b0} : pin_addr_w; // RULE23
               flash_dq_o <= pin_data_w;
               flash_dq_oe <= 1'b1;
               flash_ce_n <= 1'b0;
               st_q <= S_WLOW;
               cnt_q <= 4'h0;
            end
            S_WLOW: begin
               flash_we_n <= 1'b0; // RULE1
               cnt_q <= cnt_q + 4'h1;
               if (cnt_q == WE_CYC) begin
                  flash_we_n <= 1'b1; // RULE2
                  st_q <= S_WHOLD;
               end
            end
            S_WHOLD: begin
               // data held past the write rise, then select released
               flash_ce_n <= 1'b1;
               flash_dq_oe <= 1'b0;
               if (seq_w[21]) begin
                  st_q <= S_IDLE;
                  case (cmd_q)
                     `FCM_CMD_RESET: begin
                        fail_q <= 1'b0; // RULE7
                        if (mode_q != `FCM_MODE_SEC)
                           mode_q <= `FCM_MODE_READ; // RULE10
                     end
                     `FCM_CMD_AUTOSEL: mode_q <= `FCM_MODE_AUTOSEL; // RULE12
                     `FCM_CMD_QUERY: if (mode_q == `FCM_MODE_READ) mode_q <= `FCM_MODE_QUERY;
                     `FCM_CMD_SEC_ENTER: mode_q <= `FCM_MODE_SEC; // RULE16
                     `FCM_CMD_SEC_EXIT: mode_q <= `FCM_MODE_READ; // RULE16
                     `FCM_CMD_BUF_ABORT: abort_q <= 1'b0; // RULE11
                     `FCM_CMD_RAW: begin
                        if (wdata_q[7:0] == `FCM_SUSPEND_D)
                           esusp_q <= 1'b1; // RULE5
                        else if (wdata_q[7:0] == `FCM_RESUME_D)
                           esusp_q <= 1'b0;
                     end
                     default: mode_q <= mode_q;
                  endcase
               end else begin
                  idx_q <= idx_q + 2'h1;
                  st_q <= S_WSET;
               end
            end
            S_RLOW: begin
               flash_addr <= byte_q ? {addr_q[AW-2:0], 1'b0} : addr_q; // RULE23
               flash_ce_n <= 1'b0;
               flash_oe_n <= 1'b0;
               cnt_q <= cnt_q + 4'h1;
               if (cnt_q == RD_CYC) begin
                  flash_ce_n <= 1'b1;
                  flash_oe_n <= 1'b1;
                  rdata_q <= dq_s2_q; // RULE13 RULE14 RULE15 RULE18 RULE19 RULE20 RULE21 RULE22
                  if (cmd_q == `FCM_CMD_POLL) begin // RULE4
                     if (dq_s2_q[`FCM_DQ_FAIL])
                        fail_q <= 1'b1; // RULE7
                     if (dq_s2_q[`FCM_DQ_ABORT])
                        abort_q <= 1'b1; // RULE11
                  end
                  st_q <= S_IDLE;
               end
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end
endmodule // fcm_host

/* fcm_host_assertions.sv */
/* port checker of fcm_host: axi answers and flash strobe timing.
   assumes one clock domain, bound into every fcm_host. */
module fcm_chk #(
   parameter AW = 23
) (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // axi handshakes
   input wire s_awvalid,
   input wire s_awready,
   input wire s_wvalid,
   input wire s_wready,
   input wire s_bvalid,
   input wire s_arvalid,
   input wire s_arready,
   input wire s_rvalid,
   // flash pins
   input wire flash_ce_n,
   input wire flash_we_n,
   input wire flash_oe_n,
   input wire [AW-1:0] flash_addr,
   input wire [15:0] flash_dq_o,
   input wire flash_dq_oe
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence s_we_low;
      (!flash_we_n)[*4];
   endsequence
   sequence s_oe_low;
      (!flash_oe_n)[*8] ##1 (!flash_oe_n)[*3];
   endsequence
   AST_WE_WIDTH: assert property ($fell(flash_we_n) |-> s_we_low) else $error("write strobe short");
   AST_WE_CTX: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe) else $error("we ctx");
   AST_PIN_HOLD: assert property (!flash_we_n && $past(!flash_we_n) |->
      $stable(flash_addr) && $stable(flash_dq_o)) else $error("pins moved in write");
   AST_CE_LAST: assert property ($rose(flash_we_n) && $past(aresetn) |-> !flash_ce_n) else $error("ce early");
   AST_OE_LEN: assert property ($fell(flash_oe_n) |-> s_oe_low ##[1:4] flash_oe_n) else $error("read len");
   AST_OE_CTX: assert property (!flash_oe_n |-> !flash_ce_n && flash_we_n && !flash_dq_oe) else $error("oe ctx");
   AST_IDLE: assert property (flash_ce_n |-> flash_we_n && flash_oe_n) else $error("strobe w/o ce");
   AST_B_ANS: assert property (s_awvalid && s_awready && s_wvalid && s_wready |=> !s_awready ##1 s_bvalid)
      else $error("no write answer");
   AST_R_ANS: assert property (s_arvalid && s_arready |=> s_rvalid && !s_arready) else $error("no read answer");
endmodule // fcm_chk
bind fcm_host fcm_chk #(.AW(AW)) u_chk (
   .aclk(aclk), .aresetn(aresetn), .s_awvalid(s_awvalid), .s_awready(s_awready),
   .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bvalid(s_bvalid), .s_arvalid(s_arvalid),
   .s_arready(s_arready), .s_rvalid(s_rvalid), .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
   .flash_oe_n(flash_oe_n), .flash_addr(flash_addr), .flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe)
);

/* fcm_host_tb_top.sv */
/* bench of fcm_host driving a flash model over its pins.
   assumes the model, the checker and the shared functions beside it. */
`include "fcm_defines.vh"
`include "fcm_tb_fn.svh"
module fcm_host_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, byte_m = 0;
   logic [7:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, d;
   logic [1:0] inj = 0, r;
   wire awr, wr, bv, arr, rv, ce_n, we_n, oe_n, dq_oe;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [22:0] fa;
   wire [15:0] dqo, m_dq;
   wire [15:0] dq = dq_oe ? dqo : m_dq;
   int err_total = 0, n_compared = 0, cyc = 0;
   localparam logic [39:0] av = 40'h00_01_0e_0f_03;
   fcm_host #(.AW(23)) DUT (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awa), .s_awvalid(awv), .s_awready(awr),
      .s_wdata(wd), .s_wstrb(4'h1), .s_wvalid(wv), .s_wready(wr), .s_bresp(bresp), .s_bvalid(bv), .s_bready(bry),
      .s_araddr(ara), .s_arvalid(arv), .s_arready(arr), .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rv),
      .s_rready(rry), .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n), .flash_addr(fa),
      .flash_dq_o(dqo), .flash_dq_oe(dq_oe), .flash_dq_i(dq));
   fcm_flash_model u_flash (.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(fa), .dq(dq), .dq_i(m_dq),
      .byte_m(byte_m), .inj(inj));
   initial forever #5 aclk = ~aclk;
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         complete_run();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] v);
      bit ad, dd;
      ad = 0;
      dd = 0;
      @(posedge aclk);
      awa <= a;
      wd <= v;
      awv <= 1;
      wv <= 1;
      bry <= 1;
      while (!(ad && dd)) begin
         @(posedge aclk);
         ad |= awr;
         dd |= wr;
         awv <= !ad;
         wv <= !dd;
      end
      do @(posedge aclk); while (!bv);
      r = bresp;
      bry <= 0;
   endtask
   task automatic axr(input logic [7:0] a);
      @(posedge aclk);
      ara <= a;
      arv <= 1;
      rry <= 1;
      do @(posedge aclk); while (!arr);
      arv <= 0;
      do @(posedge aclk); while (!rv);
      d = rdata;
      r = rresp;
      rry <= 0;
   endtask
   task automatic cmd(input logic [3:0] c, input logic [1:0] e);
      axw(`FCM_REG_CTRL, {28'h0, c});
      chk("bresp", {30'h0, e}, {30'h0, r});
      do axr(`FCM_REG_STAT); while (d[0] !== 1'b0);
   endtask
   task automatic go(input logic [22:0] a, input logic [3:0] c, input logic [1:0] e);
      axw(`FCM_REG_ADDR, {9'h0, a});
      cmd(c, e);
   endtask
   task automatic raw(input logic [22:0] a, input logic [15:0] v, input logic [1:0] e);
      axw(`FCM_REG_WDATA, {16'h0, v});
      go(a, `FCM_CMD_RAW, e);
   endtask
   task automatic ck(input logic [22:0] a, input logic [1:0] m);
      go(a, `FCM_CMD_READ, `FCM_RESP_OKAY);
      axr(`FCM_REG_RDATA);
      chk("rdata", {16'h0, fcm_dval(a, m)}, d);
   endtask
   // abort, fail, suspend, mode
   task automatic ckst(input logic [4:0] e);
      axr(`FCM_REG_STAT);
      chk("status", {27'h0, e}, {27'h0, d[5:1]});
   endtask
   task automatic done(input string s);
      $display("test %s done", s);
   endtask
   function automatic logic [22:0] ra();
      return 23'($urandom);
   endfunction
   initial begin
      logic [22:0] a;
      void'($urandom(27135));
      repeat (5) @(posedge aclk);
      aresetn <= 1;
      repeat (4) ck(ra(), 2'h0);
      ckst(5'h0);
      done("array");
      cmd(`FCM_CMD_AUTOSEL, `FCM_RESP_OKAY);
      ckst(5'h1);
      repeat (2) for (int i = 0; i < 5; i++) ck(23'(av[8*i +: 8]), 2'h1);
      a = ra();
      ck({a[22:8], 8'h02}, 2'h1);
      cmd(`FCM_CMD_RESET, `FCM_RESP_OKAY);
      ckst(5'h0);
      ck(ra(), 2'h0);
      done("autoselect");
      cmd(`FCM_CMD_QUERY, `FCM_RESP_OKAY);
      for (int i = 'h40; i <= 'h50; i++) ck(23'(i), 2'h2);
      axw(`FCM_REG_CFG, 32'h1);
      byte_m <= 1;
      for (int i = 'h40; i <= 'h50; i += 3) ck(23'(i), 2'h2);
      axw(`FCM_REG_CFG, 32'h0);
      byte_m <= 0;
      cmd(`FCM_CMD_RESET, `FCM_RESP_OKAY);
      done("query");
      cmd(`FCM_CMD_SEC_ENTER, `FCM_RESP_OKAY);
      ckst(5'h3);
      cmd(`FCM_CMD_RESET, `FCM_RESP_OKAY);
      ck(ra(), 2'h3);
      raw(ra(), 16'h0020, `FCM_RESP_SLVERR);
      axw(`FCM_REG_STAT, 32'h40);
      cmd(`FCM_CMD_SEC_EXIT, `FCM_RESP_OKAY);
      ck(ra(), 2'h0);
      done("secured");
      raw(ra(), 16'h00b0, `FCM_RESP_OKAY);
      ckst(5'h4);
      cmd(`FCM_CMD_AUTOSEL, `FCM_RESP_OKAY);
      cmd(`FCM_CMD_RESET, `FCM_RESP_OKAY);
      ckst(5'h4);
      raw(ra(), 16'h0030, `FCM_RESP_OKAY);
      ckst(5'h0);
      done("suspend");
      axr(8'h18);
      chk("rresp", {30'h0, `FCM_RESP_DECERR}, {30'h0, r});
      cmd(4'h9, `FCM_RESP_SLVERR);
      axw(`FCM_REG_STAT, 32'h40);
      done("errors");
      for (int k = 1; k <= 2; k++) begin
         inj <= 2'(k);
         go((ra() & 23'h7fffdf) | 23'h2, `FCM_CMD_POLL, `FCM_RESP_OKAY);
         ckst(k == 1 ? 5'h10 : 5'h08);
         cmd(`FCM_CMD_AUTOSEL, `FCM_RESP_SLVERR);
         axw(`FCM_REG_STAT, 32'h40);
         inj <= 2'h0;
         cmd(k == 1 ? `FCM_CMD_BUF_ABORT : `FCM_CMD_RESET, `FCM_RESP_OKAY);
         ck(ra(), 2'h0);
      end
      done("abort and fail");
      complete_run();
   end
endmodule // fcm_host_tb_top

/* fcm_tb_fn.svh */
/* expected flash read data for each device mode.
   assumes inclusion at file level by the model and the bench. */
`ifndef FCM_TB_FN_SVH
`define FCM_TB_FN_SVH
localparam logic [15:0] fcm_maker = 16'h00a5; // arbitrary value
localparam logic [15:0] fcm_devid = 16'h1230; // arbitrary value
function automatic logic [15:0] fcm_dval(input logic [22:0] a, input logic [1:0] m);
   case (m)
      2'h0: return a[15:0] ^ 16'h5a5a;
      2'h1: case (a[7:0])
         8'h00: return fcm_maker;
         8'h01: return fcm_devid;
         8'h0e: return fcm_devid + 16'h1;
         8'h0f: return fcm_devid + 16'h2;
         8'h02: return 16'h0001;
         8'h03: return 16'h0080;
         default: return 16'h0;
      endcase
      2'h2: case (a[7:0])
         8'h40: return 16'h0050;
         8'h41: return 16'h0052;
         8'h42: return 16'h0049;
         8'h43: return 16'h0031;
         8'h44: return 16'h0033;
         8'h45: return 16'h0010;
         8'h46: return 16'h0002;
         8'h47: return 16'h0001;
         8'h49: return 16'h0008;
         8'h4f: return 16'h0002;
         8'h50: return 16'h0001;
         default: return 16'h0;
      endcase
      default: return a[15:0] ^ 16'hc3c3;
   endcase
endfunction
`endif
